// *** pin_model.sv ***
// Purpose: far-side model of count and direction pins
// Assumes: edges spaced well above the synchroniser delay
// Notes:   the block's drive wins whenever its enable is high
`timescale 1ns/100ps
module pin_model
  import timer_pkg::*;
(
  input  wire logic clock,     // clock
  input  wire logic drv_oe,    // block drives pin
  input  wire logic drv_level, // block pin level
  output logic      pin_level, // resolved count pin
  output logic      dir_level  // direction pin
);
  logic own_r;
  initial begin
    own_r = 1'b1;
    dir_level = 1'b1;
  end
  assign pin_level = drv_oe ? drv_level : own_r;
  // slow edges so none is lost in the synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock);
      own_r <= 1'b0;
      repeat (4) @(posedge clock);
      own_r <= 1'b1;
    end
  endtask
  task automatic set_dir(input logic up);
    dir_level <= up;
  endtask
endmodule

// *** pin_sync.sv ***
// Purpose: two-flop synchroniser and falling-edge detect per pin
// Assumes: pins are asynchronous to clock
// Notes:   edge detect looks only at the second stage
`timescale 1ns/100ps
`include "timer_cfg.svh"
module pin_sync
  import timer_pkg::*;
(
  input  wire logic                      clock,   // peripheral clock
  input  wire logic                      nrst,    // async reset, low
  input  wire logic                      ce,      // clock enable
  input  wire logic [`PIN_CHANNELS-1:0]  pin_in,  // raw pin levels
  output logic      [`PIN_CHANNELS-1:0]  level,   // synchronised level
  output logic      [`PIN_CHANNELS-1:0]  fall     // one-cycle fall pulse
);

  genvar i;
  generate
    for (i = 0; i < `PIN_CHANNELS; i++) begin : g_pin
      // per-channel flops: one process owns each variable
      logic sync1_r;
      logic sync2_r;
      logic prev_r;
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
          prev_r  <= 1'b0;
        end else if (ce) begin
          sync1_r <= pin_in[i];
          sync2_r <= sync1_r;
          prev_r  <= sync2_r;
        end
      end
      assign level[i] = sync2_r;
      assign fall[i]  = prev_r & ~sync2_r;
    end
  endgenerate

endmodule

// *** reload_timer_clock_out.sv ***
// Purpose: 16-bit reload timer/counter with up/down and clock output
// Assumes: byte register port, read data one cycle after read strobe
// Notes:   one clock domain; pins pass the pin_sync module first
//
// Functional notes
// - count is a high byte register cascaded with a low byte register.
// - select bit clear counts divided clock, set counts count pin edges.
// - count advances only while the run bit is set.
// - capture, auto-reload and baud modes chosen by clock and reload bits.
// - down-count enable clear gives classic up reload, set gives up/down.
// - in up/down, direction pin high counts up, low counts down.
// - passing FFFFh upward overflows, sets overflow flag and requests irq.
// - up overflow loads the reload byte pair into the count bytes, except in capture mode, which wraps to 0000h.
// - down count equal to reload underflows, sets flag, loads FFFFh.
// - up/down external flag toggles each wrap, raises no interrupt.
// - clock-out mode makes a fifty percent duty programmable clock.
// - clock-out steps at half clock, reloading at every overflow except in capture mode, which wraps to 0000h.
// - clock-out overflows raise no interrupt request.
// - output frequency is clock over four times 65536 minus reload.
// - clock-out drives the generated clock onto the count pin.
// - baud generation and clock output share the same reload value.
// - overflow flag sets only with both clock bits clear; software clears.
// - with a clock bit set, capture select is ignored, reload forced.
// - output enable makes the count pin an output, else an input.
`timescale 1ns/100ps
`include "timer_cfg.svh"
module reload_timer_clock_out
  import timer_pkg::*;
(
  input  wire logic       clock,                // peripheral clock, 10 MHz
  input  wire logic       nrst,                 // async reset, active low
  input  wire logic       ce,                   // clock enable, freezes all
  input  wire logic [2:0] reg_addr,             // register address
  input  wire logic [7:0] reg_wdata,            // register write data
  input  wire logic       reg_write,            // write strobe
  input  wire logic       reg_read,             // read strobe
  output logic      [7:0] reg_rdata,            // read data, next cycle
  input  wire logic       count_clock_pin_in,   // count pin level in
  output logic            count_clock_pin_out,  // count pin drive level
  output logic            count_clock_pin_oe,   // count pin drive enable
  input  wire logic       direction_pin,        // direction / external pin
  output logic            timer_irq,            // interrupt request level
  output logic            baud_overflow         // baud clock pulse
);

  control_t  control_r;
  control_t  control_nxt;
  mode_t     mode_r;
  logic [7:0] count_low_byte_r;
  logic [7:0] count_high_byte_r;
  logic [7:0] reload_low_byte_r;
  logic [7:0] reload_high_byte_r;
  logic [7:0] count_low_byte_nxt;
  logic [7:0] count_high_byte_nxt;
  logic [7:0] reload_low_byte_nxt;
  logic [7:0] reload_high_byte_nxt;
  logic [3:0] prescale_r;
  logic [3:0] prescale_nxt;
  logic       clock_out_r;
  logic       baud_overflow_r;
  logic [7:0] reg_rdata_r;

  // pin synchronisation
  logic [`PIN_CHANNELS-1:0] pin_raw;
  logic [`PIN_CHANNELS-1:0] pin_level;
  logic [`PIN_CHANNELS-1:0] pin_fall;

  assign pin_raw[`PIN_COUNT] = count_clock_pin_in;
  assign pin_raw[`PIN_DIR]   = direction_pin;

  pin_sync u_pin_sync (
    .clock  (clock),
    .nrst   (nrst),
    .ce     (ce),
    .pin_in (pin_raw),
    .level  (pin_level),
    .fall   (pin_fall)
  );

  // register decode
  wire wr_control     = reg_write && (reg_addr == `ADDR_CONTROL);
  wire wr_mode        = reg_write && (reg_addr == `ADDR_MODE);
  wire wr_reload_low  = reg_write && (reg_addr == `ADDR_RELOAD_LOW);
  wire wr_reload_high = reg_write && (reg_addr == `ADDR_RELOAD_HIGH);
  wire wr_count_low   = reg_write && (reg_addr == `ADDR_COUNT_LOW);
  wire wr_count_high  = reg_write && (reg_addr == `ADDR_COUNT_HIGH);
  control_t wr_ctrl;
  assign wr_ctrl = control_t'(reg_wdata);

  // mode decode
  wire baud_sel = control_r.receive_clock_select
                | control_r.transmit_clock_select;
  op_mode_t op_mode;
  assign op_mode = baud_sel                         ? op_baud    :
                   control_r.capture_reload_select  ? op_capture :
                   mode_r.down_count_enable         ? op_updown  :
                                                      op_reload;
  // clock-out rides on top of reload or baud, shared reload pair
  wire clock_out_mode = mode_r.clock_out_enable
                      & ~control_r.timer_counter_select;

  // count direction: only up/down mode listens to the pin
  wire count_up = (op_mode != op_updown) | pin_level[`PIN_DIR];

  // prescaler: divide by 12 normally, by 2 for clock-out and baud
  wire fast_rate  = clock_out_mode | baud_sel;
  wire [3:0] div_last = fast_rate ? `FAST_DIV_LAST : `SLOW_DIV_LAST;
  wire prescale_hit = (prescale_r >= div_last);
  assign prescale_nxt = (!control_r.run_bit || prescale_hit) ? `DIV_ZERO
                      : prescale_r + `DIV_ONE;

  // count input select
  wire tick = control_r.timer_counter_select ? pin_fall[`PIN_COUNT]
                                             : prescale_hit;
  wire step = control_r.run_bit & tick;

  wire [15:0] count  = {count_high_byte_r, count_low_byte_r};
  wire [15:0] reload = {reload_high_byte_r, reload_low_byte_r};

  wire overflow  = step & count_up & (count == `COUNT_MAX);
  wire underflow = step & ~count_up & (count == reload);
  wire wrap      = overflow | underflow;

  // external pin event; in up/down the pin is the direction only
  wire ext_event = control_r.external_enable & pin_fall[`PIN_DIR]
                 & (op_mode != op_updown);
  wire ext_reload  = ext_event & (op_mode == op_reload);
  wire ext_capture = ext_event & (op_mode == op_capture);

  // next count: reload on up wrap except in capture, which wraps to 0
  wire reload_on_ovf = overflow & (op_mode != op_capture);
  wire [15:0] count_inc = count + `COUNT_ONE;
  wire [15:0] count_dec = count - `COUNT_ONE;
  logic [15:0] count_hw;
  always_comb begin
    count_hw = count;
    if (underflow) begin
      count_hw = `COUNT_MAX;
    end else if (reload_on_ovf) begin
      count_hw = reload;
    end else if (ext_reload) begin
      count_hw = reload;
    end else if (step) begin
      count_hw = count_up ? count_inc : count_dec;
    end
  end

  // software writes to a count byte win over the hardware step
  assign count_low_byte_nxt  = wr_count_low  ? reg_wdata : count_hw[7:0];
  assign count_high_byte_nxt = wr_count_high ? reg_wdata : count_hw[15:8];

  // capture copies the count into the reload pair
  assign reload_low_byte_nxt  = wr_reload_low  ? reg_wdata
                              : ext_capture    ? count[7:0]
                              : reload_low_byte_r;
  assign reload_high_byte_nxt = wr_reload_high ? reg_wdata
                              : ext_capture    ? count[15:8]
                              : reload_high_byte_r;

  // flags: hardware set wins over a software clear in the same cycle
  wire ovf_set = wrap & ~baud_sel & ~clock_out_mode;
  wire ext_set = ext_event;
  wire ext_tog = wrap & (op_mode == op_updown);
  control_t ctrl_base;
  assign ctrl_base = wr_control ? wr_ctrl : control_r;
  always_comb begin
    control_nxt = ctrl_base;
    control_nxt.overflow_flag = ctrl_base.overflow_flag | ovf_set;
    if (ext_tog) begin
      control_nxt.external_flag = ~ctrl_base.external_flag;
    end else if (ext_set) begin
      control_nxt.external_flag = 1'b1;
    end
  end

  // read mux; reserved mode bits read as zero
  mode_t mode_read;
  assign mode_read = '{reserved: 6'h00,
                       clock_out_enable: mode_r.clock_out_enable,
                       down_count_enable: mode_r.down_count_enable};
  logic [7:0] read_sel;
  always_comb begin
    read_sel = `READ_ZERO;
    unique case (reg_addr)
      `ADDR_CONTROL:     read_sel = control_r;
      `ADDR_MODE:        read_sel = mode_read;
      `ADDR_RELOAD_LOW:  read_sel = reload_low_byte_r;
      `ADDR_RELOAD_HIGH: read_sel = reload_high_byte_r;
      `ADDR_COUNT_LOW:   read_sel = count_low_byte_r;
      `ADDR_COUNT_HIGH:  read_sel = count_high_byte_r;
      default:           read_sel = `READ_ZERO;
    endcase
  end

  // control and mode registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      control_r <= control_t'(`CONTROL_RESET);
      mode_r    <= mode_t'(`MODE_RESET);
    end else if (ce) begin
      control_r <= control_nxt;
      if (wr_mode) begin
        mode_r <= mode_t'(reg_wdata);
      end
    end
  end

  // count and reload byte registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_low_byte_r   <= `BYTE_RESET;
      count_high_byte_r  <= `BYTE_RESET;
      reload_low_byte_r  <= `BYTE_RESET;
      reload_high_byte_r <= `BYTE_RESET;
    end else if (ce) begin
      count_low_byte_r   <= count_low_byte_nxt;
      count_high_byte_r  <= count_high_byte_nxt;
      reload_low_byte_r  <= reload_low_byte_nxt;
      reload_high_byte_r <= reload_high_byte_nxt;
    end
  end

  // prescaler; cleared while stopped so a start is phase-clean
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prescale_r <= `DIV_ZERO;
    end else if (ce) begin
      prescale_r <= prescale_nxt;
    end
  end

  // clock output: one toggle per overflow, two per period
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clock_out_r <= 1'b0;
    end else if (ce) begin
      if (clock_out_mode && overflow) begin
        clock_out_r <= ~clock_out_r;
      end
    end
  end

  // baud pulse and read data
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      baud_overflow_r <= 1'b0;
      reg_rdata_r     <= `READ_ZERO;
    end else if (ce) begin
      baud_overflow_r <= overflow & baud_sel;
      reg_rdata_r     <= reg_read ? read_sel : `READ_ZERO;
    end
  end

  assign count_clock_pin_out = clock_out_r;
  assign count_clock_pin_oe  = mode_r.clock_out_enable;
  // external flag requests service only outside up/down
  assign timer_irq = control_r.overflow_flag
                   | (control_r.external_flag
                      & ~mode_r.down_count_enable);
  assign baud_overflow = baud_overflow_r;
  assign reg_rdata     = reg_rdata_r;

endmodule

// *** testbench.sv ***
// Purpose: self-checking bench of the reload timer
// Assumes: ce held high, clock enable has no own scenario
// Notes:   pins come from pin_model
`timescale 1ns/100ps
module testbench
  import timer_pkg::*;
;
  logic        clock;
  logic        nrst;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata;
  logic        pin_out;
  logic        pin_oe;
  logic        pin_in;
  logic        dir;
  logic        irq;
  logic        baud;
  logic        pin_q;
  logic        tog;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cycles = 0;
  reload_timer_clock_out i_dut (.clock(clock), .nrst(nrst), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .count_clock_pin_in(pin_in), .count_clock_pin_out(pin_out),
    .count_clock_pin_oe(pin_oe), .direction_pin(dir),
    .timer_irq(irq), .baud_overflow(baud));
  pin_model i_pin (.clock(clock), .drv_oe(pin_oe), .drv_level(pin_out),
    .pin_level(pin_in), .dir_level(dir));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  assign tog = pin_out ^ pin_q;
  always @(posedge clock) begin
    pin_q <= pin_out;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic finish_test;
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    // strobe still up from a write just made: let one edge pass
    if (reg_write) @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, string w);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    // read data stand in the cycle after the strobe; take them at its end
    @(posedge clock);
    chk(w, {8'h00, e}, {8'h00, reg_rdata});
  endtask
  // cycles between two events: pin toggles or baud pulses
  task automatic gap(input logic sel, output logic [15:0] g);
    int k;
    g = 16'h0000;
    k = 0;
    while (k < 2 && g < 16'h0100) begin
      @(posedge clock);
      if (k == 1) g++;
      if (sel ? baud : tog) k++;
    end
  endtask
  task automatic t_regs;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00, "reset");
    for (int a = 2; a < 8; a++) begin
      wr(3'(a), 8'(8'h50 + a));
      rd(3'(a), a < 6 ? 8'(8'h50 + a) : 8'h00, "byte");
    end
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h03, "mode");
    chk("pin enable", 16'h0001, {15'h0, pin_oe});
    wr(3'h1, 8'h00);
  endtask
  task automatic t_updown;
    wr(3'h1, 8'h01);
    wr(3'h2, 8'h34);
    wr(3'h3, 8'h12);
    wr(3'h4, 8'hFF);
    wr(3'h5, 8'hFF);
    wr(3'h0, 8'h04);
    repeat (15) @(posedge clock);
    rd(3'h4, 8'h34, "up low");
    rd(3'h5, 8'h12, "up high");
    rd(3'h0, 8'hC4, "up flags");
    chk("up irq", 16'h0001, {15'h0, irq});
    wr(3'h0, 8'h00);
    i_pin.set_dir(1'b0);
    wr(3'h4, 8'h35);
    wr(3'h0, 8'h04);
    repeat (27) @(posedge clock);
    rd(3'h4, 8'hFF, "down low");
    rd(3'h5, 8'hFF, "down high");
    rd(3'h0, 8'hC4, "down flags");
  endtask
  task automatic t_classic;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'hCD);
    wr(3'h3, 8'hAB);
    wr(3'h4, 8'hFF);
    wr(3'h0, 8'h04);
    repeat (15) @(posedge clock);
    rd(3'h4, 8'hCD, "classic low");
    rd(3'h5, 8'hAB, "classic high");
    rd(3'h0, 8'h84, "classic flags");
    wr(3'h0, 8'h00);
    @(posedge clock);
    chk("irq cleared", 16'h0000, {15'h0, irq});
  endtask
  task automatic t_counter;
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    wr(3'h0, 8'h06);
    i_pin.pulse(3);
    repeat (4) @(posedge clock);
    rd(3'h4, 8'h03, "edges");
    wr(3'h0, 8'h02);
    i_pin.pulse(2);
    repeat (4) @(posedge clock);
    rd(3'h4, 8'h03, "stopped");
    wr(3'h0, 8'h00);
  endtask
  task automatic t_clock_out;
    logic [15:0] r;
    logic [15:0] g;
    for (int i = 0; i < 2; i++) begin
      r = i ? 16'hFFFD : 16'hFFFF;
      wr(3'h1, 8'h02);
      wr(3'h0, 8'h00);
      wr(3'h2, r[7:0]);
      wr(3'h3, r[15:8]);
      wr(3'h4, r[7:0]);
      wr(3'h5, r[15:8]);
      wr(3'h0, 8'h04);
      gap(1'b0, g);
      gap(1'b0, g);
      chk("half period", 16'(2 * (17'h10000 - r)), g);
      chk("pin driven", 16'h0001, {15'h0, pin_oe});
      chk("irq quiet", 16'h0000, {15'h0, irq});
      rd(3'h0, 8'h04, "no flag");
    end
    wr(3'h0, 8'h15);
    gap(1'b1, g);
    gap(1'b1, g);
    chk("baud gap", 16'h0006, g);
    gap(1'b0, g);
    gap(1'b0, g);
    chk("shared half", 16'h0006, g);
    rd(3'h0, 8'h15, "baud flag");
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
  endtask
  initial begin
    nrst = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_regs();
    t_updown();
    t_classic();
    t_counter();
    t_clock_out();
    finish_test();
  end
endmodule

// *** timer_cfg.svh ***
// Purpose: named constants of the reload timer with clock output
// Assumes: byte-wide register port, 3-bit register address
// Notes:   definitions only, no logic
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// register addresses on the plain register port
`define ADDR_CONTROL     3'h0
`define ADDR_MODE        3'h1
`define ADDR_RELOAD_LOW  3'h2
`define ADDR_RELOAD_HIGH 3'h3
`define ADDR_COUNT_LOW   3'h4
`define ADDR_COUNT_HIGH  3'h5

// reset values
`define CONTROL_RESET    8'h00
`define MODE_RESET       8'h00
`define BYTE_RESET       8'h00
`define READ_ZERO        8'h00

// count limits
`define COUNT_MAX        16'hFFFF
`define COUNT_ONE        16'h0001

// prescaler: last state of divide-by-12 and divide-by-2
`define SLOW_DIV_LAST    4'hB
`define FAST_DIV_LAST    4'h1
`define DIV_ZERO         4'h0
`define DIV_ONE          4'h1

// synchronised pin channels and their positions
`define PIN_CHANNELS     2
`define PIN_COUNT        0
`define PIN_DIR          1

`endif

// *** timer_chk.sv ***
// Purpose: port-level assertions for the reload timer
// Assumes: ce held high; shadows follow register writes
// Notes:   bound to the top module at the foot
`timescale 1ns/100ps
module timer_chk
  import timer_pkg::*;
(
  input wire logic       clock,               // clock
  input wire logic       nrst,                // reset, low
  input wire logic [2:0] reg_addr,            // address
  input wire logic [7:0] reg_wdata,           // write data
  input wire logic       reg_write,           // write strobe
  input wire logic       reg_read,            // read strobe
  input wire logic [7:0] reg_rdata,           // read data
  input wire logic       count_clock_pin_out, // pin level
  input wire logic       count_clock_pin_oe,  // pin enable
  input wire logic       timer_irq,           // irq level
  input wire logic       baud_overflow        // baud pulse
);
  logic oe_r;
  logic tcs_r;
  logic run_r;
  logic clk_r;
  logic co;
  assign co = oe_r & ~tcs_r & run_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oe_r  <= 1'b0;
      tcs_r <= 1'b0;
      run_r <= 1'b0;
      clk_r <= 1'b0;
    end else if (reg_write && reg_addr == 3'h1) begin
      oe_r <= reg_wdata[1];
    end else if (reg_write && reg_addr == 3'h0) begin
      clk_r <= |reg_wdata[5:4];
      run_r <= reg_wdata[2];
      tcs_r <= reg_wdata[1];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_rdata_idle:
    assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_reload_back:
    assert property (reg_write && reg_addr == 3'h2 ##1 reg_read &&
      reg_addr == 3'h2 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("reload byte lost");
  a_mode_zero:
    assert property (reg_read && reg_addr == 3'h1 |=>
      reg_rdata[7:2] == 6'h00) else $error("mode spare bits set");
  a_unmapped_zero:
    assert property (reg_read && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_oe_follow:
    assert property (reg_write && reg_addr == 3'h1 |=>
      count_clock_pin_oe == oe_r) else $error("pin enable wrong");
  a_pin_quiet:
    assert property ($changed(count_clock_pin_out) |-> co || $past(co))
    else $error("pin moved outside clock out");
  a_toggle_gap:
    assert property ($changed(count_clock_pin_out) |=>
      $stable(count_clock_pin_out)) else $error("toggle too fast");
  a_irq_clkout:
    assert property ($rose(timer_irq) && !$past(reg_write) |-> !$past(co))
    else $error("irq in clock out");
  a_baud_sel:
    assert property (baud_overflow |-> clk_r || $past(clk_r))
    else $error("baud pulse without select");
  a_baud_gap:
    assert property (baud_overflow |=> !baud_overflow)
    else $error("baud pulse too long");
  c_toggle: cover property ($changed(count_clock_pin_out));
  c_baud: cover property (baud_overflow);
  c_irq: cover property ($rose(timer_irq));
endmodule
bind reload_timer_clock_out timer_chk u_chk (.clock(clock), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .count_clock_pin_out(count_clock_pin_out),
  .count_clock_pin_oe(count_clock_pin_oe), .timer_irq(timer_irq),
  .baud_overflow(baud_overflow));

// *** timer_pkg.sv ***
// Purpose: types shared by the reload timer files
// Assumes: nothing beyond the constants header
// Notes:   field order matches the register bit order, msb first
package timer_pkg;

  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_enable;
    logic run_bit;
    logic timer_counter_select;
    logic capture_reload_select;
  } control_t;

  typedef struct packed {
    logic [5:0] reserved;
    logic       clock_out_enable;
    logic       down_count_enable;
  } mode_t;

  typedef enum logic [1:0] {
    op_capture,
    op_reload,
    op_updown,
    op_baud
  } op_mode_t;

endpackage
